// file: inc/tdcr_cfg.svh
// Constants of the event readout: geometry, word layout, reset values.
// Included by the package and by the readout module; guarded.
`ifndef TDCR_CFG_SVH
`define TDCR_CFG_SVH
`define TDCR_NCH 4
`define TDCR_TAPS 128
`define TDCR_HALF 64
`define TDCR_BIN_PS 50
`define TDCR_HALF_PS 3200
`define TDCR_TS_MAX 12'hfff
`define TDCR_EVT_DEPTH 7
`define TDCR_OUT_DEPTH 8
`define TDCR_DT_W 16
`define TDCR_CHEN_RST 4'hf
`define TDCR_PW_MAX 8'hff
`define TDCR_HAM_DW 16
`define TDCR_HAM_CW 21
`define TDCR_HAM_PB 5
`define TDCR_F_SYNC 15
`define TDCR_F_LOCK 14
`define TDCR_F_EPOCH 13
`define TDCR_TY_DATA 2'h0
`define TDCR_TY_EPOCH 2'h1
`define TDCR_TY_ERR 2'h2
`define TDCR_ERR_TS 8'h01
`define TDCR_ERR_EP 8'h02
`define TDCR_PAIRS32 5'h10
`define TDCR_PAIRS24 5'h0c
`endif

// file: inc/tdcr_pkg.sv
// Types and helper functions of the event readout.
// Needs tdcr_cfg.svh on the include path.
`include "tdcr_cfg.svh"
package tdcr_pkg;
  typedef logic [`TDCR_HAM_CW-1:0] tdcr_ham_t;

  typedef struct packed {
    logic [1:0] hit;
    logic [5:0] ft1;
    logic [5:0] ft0;
    tdcr_ham_t prot;
  } tdcr_evt_t;

  typedef enum {TDCR_SCAN, TDCR_HALF1} tdcr_ring_t;

  // Even-parity single-error-correcting code, parity at powers of two
  function automatic tdcr_ham_t tdcr_ham_enc(input logic [`TDCR_HAM_DW-1:0] d);
    tdcr_ham_t c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i <= `TDCR_HAM_CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i-1] = d[k];
        k++;
      end
    end
    for (int i = 1; i <= `TDCR_HAM_CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        for (int p = 0; p < `TDCR_HAM_PB; p++) begin
          if (i[p]) c[(1 << p) - 1] = c[(1 << p) - 1] ^ c[i-1];
        end
      end
    end
    return c;
  endfunction

  function automatic logic [`TDCR_HAM_DW-1:0] tdcr_ham_dec(input tdcr_ham_t c);
    tdcr_ham_t f;
    logic [`TDCR_HAM_PB-1:0] s;
    logic [`TDCR_HAM_DW-1:0] d;
    int k;
    f = c;
    s = '0;
    d = '0;
    k = 0;
    for (int i = 1; i <= `TDCR_HAM_CW; i++) begin
      if (c[i-1]) s = s ^ `TDCR_HAM_PB'(i);
    end
    if (s != '0 && int'(s) <= `TDCR_HAM_CW) f[int'(s)-1] = ~f[int'(s)-1];
    for (int i = 1; i <= `TDCR_HAM_CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = f[i-1];
        k++;
      end
    end
    return d;
  endfunction

  // First edge in one half; b[0] is the sample just before the half
  function automatic logic [6:0] tdcr_find_edge(input logic [`TDCR_HALF:0] b,
                                               input logic rise);
    logic [6:0] r;
    r = '0;
    for (int i = `TDCR_HALF - 1; i >= 0; i--) begin
      if (rise ? (b[i+1] & ~b[i]) : (~b[i+1] & b[i])) r = {1'b1, 6'(i)};
    end
    return r;
  endfunction
endpackage

// file: inc/tdcr_strm_if.sv
// Valid/ready word stream between the readout and its FIFOs.
// Producer drives valid and data, consumer drives ready.
`timescale 1ns/100ps
interface tdcr_strm_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: src/tdcr_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Same clock on both sides; W must match the width of both streams.
`timescale 1ns/100ps
module tdcr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  tdcr_strm_if.snk wr,
  tdcr_strm_if.src rd,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [CW-1:0] cnt;
  logic push;
  logic pop;

  assign wr.ready = (cnt != CW'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rp];
  assign level = cnt;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) mem[wp] <= wr.data;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      if (push && !pop) cnt <= cnt + 1'b1;
      else if (pop && !push) cnt <= cnt - 1'b1;
    end
  end
endmodule

// file: src/tdcr_readout.sv
// Digital side of a four-channel delay-line time-to-digital converter.
// Assumes the tap pattern arrives from the analog core as a bus, and the
// uplink strobes and slow-control stream are already on this clock.
//
// What this block does
// - Each channel's 128-tap hit pattern, 50 ps per tap, is captured.
// - Pattern splits into two 64-tap halves, each encoding rising and falling edges.
// - Lock error is flagged when either window comparator trips; DAC codes driven out.
// - Uplink word enables channels individually; all four enabled after reset.
// - After readout init channels stay off until the first epoch event.
// - A 12-bit time-stamp counter counts every clock.
// - Each time-stamp overflow increments a 24-bit epoch counter.
// - Rising sync edge clears the time stamp on the second clock edge after sync is sampled.
// - Time stamp other than 4095 at sync inserts a counter-sync error word.
// - Uplink epoch value loads at next sync; mismatch inserts epoch-sync error.
// - Eight independent event FIFOs, one per channel per edge type.
// - FIFO word holds both halves' data, time stamp and Hamming-coded flags.
// - Epoch entries store low 12 epoch bits, Hamming-protected, instead of time stamp.
// - Event FIFOs hold seven, never overrun, one entry kept for epochs.
// - Dead-time counters count cycles each FIFO holds six or more entries.
// - Token ring emits one 24-bit event per edge with channel, edge, stamp, fine.
// - Events ordered by epoch, separated by epoch words.
// - 24-bit mode passes ring words; 32-bit mode uses pulse_width_calc.
// - 32-bit mode pairs edges into rising stamp, fine time and 8-bit width.
// - Width setting 0..3 selects 1, 2, 4 or 8 bins per step.
// - Slow-control words merge into the stream after pulse_width_calc.
// - Output can be spread over two double-data-rate serial lanes.
`timescale 1ns/100ps
`include "tdcr_cfg.svh"
module tdcr_readout
  import tdcr_pkg::*;
#(
  parameter int EVT_DEPTH = `TDCR_EVT_DEPTH,
  parameter int OUT_DEPTH = `TDCR_OUT_DEPTH,
  parameter int DT_W = `TDCR_DT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`TDCR_NCH*`TDCR_TAPS-1:0] hit_pattern,
  input wire logic sync_in,
  input wire logic cmp_hi,
  input wire logic cmp_lo,
  input wire logic cfg_we,
  input wire logic [`TDCR_NCH-1:0] cfg_chan_en,
  input wire logic [9:0] cfg_dac_hi,
  input wire logic [9:0] cfg_dac_lo,
  input wire logic epoch_init_we,
  input wire logic [23:0] epoch_init,
  input wire logic ro_init,
  input wire logic cfg_mode32,
  input wire logic [1:0] cfg_pw_sel,
  input wire logic cfg_dual,
  input wire logic sc_valid,
  input wire logic [31:0] sc_data,
  output logic sc_ready,
  output logic [9:0] dac_hi,
  output logic [9:0] dac_lo,
  output logic lock_err,
  output logic [11:0] ts_count,
  output logic [23:0] epoch_count,
  output logic [`TDCR_NCH-1:0] chan_active,
  output logic [2*`TDCR_NCH*DT_W-1:0] dead_time,
  output logic [1:0] ser_rise,
  output logic [1:0] ser_fall,
  output logic [1:0] ser_frame
);
  localparam int NF = 2 * `TDCR_NCH;
  localparam int EW = $bits(tdcr_evt_t);
  localparam int LW = $clog2(EVT_DEPTH + 1);

  // Pin synchronisers
  logic [`TDCR_NCH*`TDCR_TAPS-1:0] hit_s1;
  logic [`TDCR_NCH*`TDCR_TAPS-1:0] hit_s2;
  logic [`TDCR_NCH-1:0] hit_last;
  logic [2:0] sync_s;
  logic [1:0] hi_s;
  logic [1:0] lo_s;
  logic sync_rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      hit_s1 <= '0;
      hit_s2 <= '0;
      sync_s <= '0;
      hi_s <= '0;
      lo_s <= '0;
    end else begin
      hit_s1 <= hit_pattern;
      hit_s2 <= hit_s1;
      sync_s <= {sync_s[1:0], sync_in};
      hi_s <= {hi_s[0], cmp_hi};
      lo_s <= {lo_s[0], cmp_lo};
    end
  end

  assign sync_rise = sync_s[1] & ~sync_s[2];

  // Configuration held from the uplink
  logic [`TDCR_NCH-1:0] chan_en;
  logic ro_hold;
  logic ring_epoch;

  always_ff @(posedge clk) begin
    if (rst) begin
      chan_en <= `TDCR_CHEN_RST;
      dac_hi <= '0;
      dac_lo <= '0;
      lock_err <= 1'b0;
    end else begin
      if (cfg_we) begin
        chan_en <= cfg_chan_en;
        dac_hi <= cfg_dac_hi;
        dac_lo <= cfg_dac_lo;
      end
      lock_err <= hi_s[1] | lo_s[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) ro_hold <= 1'b0;
    else if (ro_init) ro_hold <= 1'b1;
    else if (ring_epoch) ro_hold <= 1'b0;
  end

  assign chan_active = chan_en & ~{`TDCR_NCH{ro_hold}};

  // Time stamp and epoch
  logic ep_pend;
  logic [23:0] ep_val;
  logic epoch_tick;
  logic [23:0] next_epoch;
  logic sync_seen;
  logic ts_err_set;
  logic ep_err_set;

  assign epoch_tick = sync_rise || (ts_count == `TDCR_TS_MAX);
  assign next_epoch = (sync_rise && ep_pend) ? ep_val : epoch_count + 1'b1;
  assign ts_err_set = sync_rise && (ts_count != `TDCR_TS_MAX);
  assign ep_err_set = sync_rise && ep_pend && (ep_val != epoch_count + 1'b1);

  always_ff @(posedge clk) begin
    if (rst) begin
      ts_count <= '0;
      epoch_count <= '0;
      sync_seen <= 1'b0;
    end else begin
      ts_count <= sync_rise ? '0 : ts_count + 1'b1;
      if (epoch_tick) begin
        epoch_count <= next_epoch;
        sync_seen <= sync_rise;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ep_pend <= 1'b0;
      ep_val <= '0;
    end else if (epoch_init_we) begin
      ep_pend <= 1'b1;
      ep_val <= epoch_init;
    end else if (sync_rise) begin
      ep_pend <= 1'b0;
    end
  end

  // Encoders, event FIFOs and dead-time counters
  logic head_v [NF];
  tdcr_evt_t head_d [NF];
  logic [`TDCR_HAM_DW-1:0] dec [NF];
  logic [NF-1:0] pop;

  always_ff @(posedge clk) begin
    for (int c = 0; c < `TDCR_NCH; c++) begin
      hit_last[c] <= hit_s2[c*`TDCR_TAPS + `TDCR_TAPS - 1];
    end
  end

  for (genvar c = 0; c < `TDCR_NCH; c++) begin : g_ch
    logic [`TDCR_TAPS:0] pat;
    assign pat = {hit_s2[c*`TDCR_TAPS +: `TDCR_TAPS], hit_last[c]};
    for (genvar e = 0; e < 2; e++) begin : g_edge
      localparam int F = c * 2 + e;
      logic [6:0] h0;
      logic [6:0] h1;
      logic [1:0] hit2;
      logic [LW-1:0] lvl;
      logic [DT_W-1:0] dead;
      tdcr_evt_t mark_w;
      tdcr_evt_t data_w;
      tdcr_strm_if #(.W(EW)) ev_in ();
      tdcr_strm_if #(.W(EW)) ev_out ();

      assign h0 = tdcr_find_edge(pat[`TDCR_HALF:0], 1'(e == 0));
      assign h1 = tdcr_find_edge(pat[`TDCR_TAPS:`TDCR_HALF], 1'(e == 0));
      assign hit2 = {h1[6], h0[6]} & {2{chan_active[c]}};
      assign data_w = '{hit: hit2, ft1: h1[5:0], ft0: h0[5:0],
                        prot: tdcr_ham_enc({sync_seen, lock_err, 2'b00, ts_count})};
      assign mark_w = '{hit: 2'b00, ft1: 6'h00, ft0: 6'h00,
                        prot: tdcr_ham_enc({sync_rise, lock_err, 2'b10,
                                            next_epoch[11:0]})};
      // Data may only use all but the last slot
      assign ev_in.valid = epoch_tick ||
                           ((hit2 != 2'b00) && (lvl < LW'(EVT_DEPTH - 1)));
      assign ev_in.data = epoch_tick ? mark_w : data_w;

      tdcr_fifo #(.W(EW), .DEPTH(EVT_DEPTH)) u_evt (
        .clk(clk),
        .rst(rst),
        .wr(ev_in),
        .rd(ev_out),
        .level(lvl)
      );

      assign head_v[F] = ev_out.valid;
      assign head_d[F] = ev_out.data;
      assign ev_out.ready = pop[F];
      assign dec[F] = tdcr_ham_dec(head_d[F].prot);

      always_ff @(posedge clk) begin
        if (rst) dead <= '0;
        else if (lvl >= LW'(EVT_DEPTH - 1)) dead <= dead + 1'b1;
      end
      assign dead_time[F*DT_W +: DT_W] = dead;
    end
  end

  // Token ring
  tdcr_ring_t state;
  tdcr_ring_t next_state;
  logic [2:0] tok;
  logic [2:0] next_tok;
  logic ring_v;
  logic next_ring_v;
  logic [23:0] ring_w;
  logic [23:0] next_ring_w;
  logic ring_take;
  logic all_mark;
  logic [NF-1:0] mark_vec;
  logic [`TDCR_HAM_DW-1:0] mark_dec;
  logic blocked;

  always_comb begin
    mark_vec = '0;
    mark_dec = '0;
    blocked = 1'b0;
    for (int f = NF - 1; f >= 0; f--) begin
      if (head_v[f] && dec[f][`TDCR_F_EPOCH]) begin
        mark_vec[f] = 1'b1;
        mark_dec = dec[f];
      end
      if (head_v[f] && !dec[f][`TDCR_F_EPOCH]) blocked = 1'b1;
    end
    all_mark = (mark_vec != '0) && !blocked;
  end

  always_comb begin
    next_state = state;
    next_tok = tok;
    next_ring_v = ring_v && !ring_take;
    next_ring_w = ring_w;
    pop = '0;
    ring_epoch = 1'b0;
    if (!ring_v || ring_take) begin
      case (state)
        TDCR_SCAN: begin
          if (all_mark) begin
            pop = mark_vec;
            ring_epoch = 1'b1;
            next_ring_v = 1'b1;
            next_ring_w = {`TDCR_TY_EPOCH, mark_dec[`TDCR_F_SYNC], mark_dec[`TDCR_F_LOCK],
                           8'h00, mark_dec[11:0]};
          end else if (head_v[tok] && !dec[tok][`TDCR_F_EPOCH]) begin
            next_ring_v = 1'b1;
            if (head_d[tok].hit[0]) begin
              next_ring_w = {`TDCR_TY_DATA, tok, dec[tok][11:0], 1'b0, head_d[tok].ft0};
              if (head_d[tok].hit[1]) begin
                next_state = TDCR_HALF1;
              end else begin
                pop[tok] = 1'b1;
                next_tok = tok + 1'b1;
              end
            end else begin
              next_ring_w = {`TDCR_TY_DATA, tok, dec[tok][11:0], 1'b1, head_d[tok].ft1};
              pop[tok] = 1'b1;
              next_tok = tok + 1'b1;
            end
          end else begin
            next_tok = tok + 1'b1;
          end
        end
        TDCR_HALF1: begin
          next_ring_v = 1'b1;
          next_ring_w = {`TDCR_TY_DATA, tok, dec[tok][11:0], 1'b1, head_d[tok].ft1};
          pop[tok] = 1'b1;
          next_tok = tok + 1'b1;
          next_state = TDCR_SCAN;
        end
        default: next_state = TDCR_SCAN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= TDCR_SCAN;
      tok <= '0;
      ring_v <= 1'b0;
      ring_w <= '0;
    end else begin
      state <= next_state;
      tok <= next_tok;
      ring_v <= next_ring_v;
      ring_w <= next_ring_w;
    end
  end

  // pulse_width_calc
  logic pw_v;
  logic [31:0] pw_w;
  logic pw_take;
  logic [1:0] rch;
  logic [18:0] r_tf [`TDCR_NCH];
  logic [`TDCR_NCH-1:0] r_pend;
  logic [18:0] diff;
  logic [18:0] scaled;
  logic [7:0] pw_val;

  assign ring_take = ring_v && (!pw_v || pw_take);
  assign rch = ring_w[21:20];
  assign diff = ring_w[18:0] - r_tf[rch];
  assign scaled = diff >> cfg_pw_sel;
  assign pw_val = (scaled > 19'(`TDCR_PW_MAX)) ? `TDCR_PW_MAX : scaled[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      pw_v <= 1'b0;
      pw_w <= '0;
      r_pend <= '0;
      for (int c = 0; c < `TDCR_NCH; c++) r_tf[c] <= '0;
    end else begin
      if (pw_take) pw_v <= 1'b0;
      if (ring_take) begin
        if (!cfg_mode32) begin
          pw_v <= 1'b1;
          pw_w <= {8'h00, ring_w};
        end else if (ring_w[23:22] != `TDCR_TY_DATA) begin
          pw_v <= 1'b1;
          pw_w <= {ring_w[23:22], 8'h00, ring_w[21:0]};
        end else if (!ring_w[19]) begin
          r_pend[rch] <= 1'b1;
          r_tf[rch] <= ring_w[18:0];
        end else if (r_pend[rch]) begin
          r_pend[rch] <= 1'b0;
          pw_v <= 1'b1;
          pw_w <= {`TDCR_TY_DATA, rch, 1'b0, r_tf[rch], pw_val};
        end
      end
    end
  end

  // Merge of error and slow-control words
  logic err_ts;
  logic err_ep;
  logic err_take;
  logic [7:0] err_code;
  logic [31:0] err_word;
  tdcr_strm_if #(.W(32)) out_in ();
  tdcr_strm_if #(.W(32)) out_q ();

  assign err_code = err_ts ? `TDCR_ERR_TS : `TDCR_ERR_EP;
  assign err_word = cfg_mode32 ? {`TDCR_TY_ERR, 22'h000000, err_code}
                               : {8'h00, `TDCR_TY_ERR, 14'h0000, err_code};
  assign err_take = (err_ts || err_ep) && out_in.ready;
  assign sc_ready = out_in.ready && !err_ts && !err_ep;
  assign pw_take = pw_v && sc_ready && !sc_valid;
  assign out_in.valid = err_ts || err_ep || sc_valid || pw_v;
  assign out_in.data = (err_ts || err_ep) ? err_word : (sc_valid ? sc_data : pw_w);

  always_ff @(posedge clk) begin
    if (rst) begin
      err_ts <= 1'b0;
      err_ep <= 1'b0;
    end else begin
      err_ts <= ts_err_set || (err_ts && !err_take);
      err_ep <= ep_err_set || (err_ep && !(err_take && !err_ts));
    end
  end

  tdcr_fifo #(.W(32), .DEPTH(OUT_DEPTH)) u_out (
    .clk(clk),
    .rst(rst),
    .wr(out_in),
    .rd(out_q),
    .level()
  );

  // Serial lanes, two bits per clock, first bit on the rising phase
  logic lane_sel;
  logic [1:0] busy;

  assign out_q.ready = !busy[lane_sel];

  always_ff @(posedge clk) begin
    if (rst) lane_sel <= 1'b0;
    else if (!cfg_dual) lane_sel <= 1'b0;
    else if (out_q.valid && out_q.ready) lane_sel <= ~lane_sel;
  end

  for (genvar l = 0; l < 2; l++) begin : g_lane
    logic [31:0] sh;
    logic [4:0] cnt;
    logic load;
    assign load = out_q.valid && (lane_sel == 1'(l)) && !busy[l];
    always_ff @(posedge clk) begin
      if (rst) begin
        sh <= '0;
        cnt <= '0;
        busy[l] <= 1'b0;
        ser_rise[l] <= 1'b0;
        ser_fall[l] <= 1'b0;
        ser_frame[l] <= 1'b0;
      end else if (load) begin
        sh <= cfg_mode32 ? out_q.data : {out_q.data[23:0], 8'h00};
        cnt <= cfg_mode32 ? `TDCR_PAIRS32 : `TDCR_PAIRS24;
        busy[l] <= 1'b1;
        ser_frame[l] <= 1'b0;
      end else if (busy[l]) begin
        ser_rise[l] <= sh[31];
        ser_fall[l] <= sh[30];
        ser_frame[l] <= 1'b1;
        sh <= {sh[29:0], 2'b00};
        cnt <= cnt - 1'b1;
        busy[l] <= (cnt != 5'h01);
      end else begin
        ser_frame[l] <= 1'b0;
      end
    end
  end
endmodule

// file: sim/tdcr_readout_chk.sv
// Port-level checks of the event readout, bound into every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tdcr_readout_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_in,
  input wire logic cmp_hi,
  input wire logic cmp_lo,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_chan_en,
  input wire logic [9:0] cfg_dac_hi,
  input wire logic [9:0] cfg_dac_lo,
  input wire logic ro_init,
  input wire logic cfg_mode32,
  input wire logic sc_ready,
  input wire logic [9:0] dac_hi,
  input wire logic [9:0] dac_lo,
  input wire logic lock_err,
  input wire logic [11:0] ts_count,
  input wire logic [23:0] epoch_count,
  input wire logic [3:0] chan_active,
  input wire logic [1:0] ser_frame
);
  logic [5:0] fl;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Length of the current frame on lane 0
  always_ff @(posedge clk) begin
    if (rst || !ser_frame[0]) begin
      fl <= 6'h0;
    end else begin
      fl <= fl + 6'h1;
    end
  end
  a_ts_step: assert property (ts_count != 12'h0 |-> ts_count == $past(ts_count) + 12'h1)
    else $error("time stamp skipped");
  a_ts_wrap: assert property (ts_count == 12'hfff |=> ts_count == 12'h0)
    else $error("time stamp did not wrap");
  a_epoch_at_zero: assert property (!$past(rst) && epoch_count != $past(epoch_count)
    |-> ts_count == 12'h0)
    else $error("epoch moved away from stamp zero");
  a_sync_clear: assert property ($rose(sync_in) |-> ##3 ts_count == 12'h0)
    else $error("sync did not clear stamp");
  a_lock_lag: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> lock_err == $past(cmp_hi | cmp_lo, 3))
    else $error("lock flag wrong");
  a_dac_load: assert property (cfg_we |=> dac_hi == $past(cfg_dac_hi)
    && dac_lo == $past(cfg_dac_lo))
    else $error("dac code not loaded");
  a_chan_subset: assert property (cfg_we |=> (chan_active & ~$past(cfg_chan_en)) == 4'h0)
    else $error("disabled channel active");
  a_init_off: assert property (ro_init |=> chan_active == 4'h0)
    else $error("channels live after init");
  a_frame_len: assert property ($fell(ser_frame[0])
    |-> fl == (cfg_mode32 ? 6'h10 : 6'h0c))
    else $error("frame length wrong");
  c_frame32: cover property ($fell(ser_frame[0]) && cfg_mode32);
  c_sync: cover property ($rose(sync_in));
  c_full: cover property (!sc_ready);
  c_lock: cover property ($rose(lock_err));
endmodule

bind tdcr_readout tdcr_readout_chk u_chk (.clk(clk), .rst(rst), .sync_in(sync_in),
  .cmp_hi(cmp_hi), .cmp_lo(cmp_lo), .cfg_we(cfg_we), .cfg_chan_en(cfg_chan_en),
  .cfg_dac_hi(cfg_dac_hi), .cfg_dac_lo(cfg_dac_lo), .ro_init(ro_init),
  .cfg_mode32(cfg_mode32), .sc_ready(sc_ready), .dac_hi(dac_hi), .dac_lo(dac_lo),
  .lock_err(lock_err), .ts_count(ts_count), .epoch_count(epoch_count),
  .chan_active(chan_active), .ser_frame(ser_frame));

// file: sim/tdcr_backend_model.sv
// Far-end receiver: rebuilds words from the two serial lanes.
// Assumes frame is high only while bits are valid, with idle between words.
`timescale 1ns/100ps
module tdcr_backend_model (
  input wire logic clk,
  input wire logic [1:0] rise,
  input wire logic [1:0] fall,
  input wire logic [1:0] frame,
  output logic [1:0] got,
  output logic [31:0] w0,
  output logic [31:0] w1
);
  logic [1:0] fp = 2'h0;
  // Two bits a cycle, most significant first
  always_ff @(posedge clk) begin
    fp <= frame;
    got <= fp & ~frame;
    if (frame[0]) w0 <= {w0[29:0], rise[0], fall[0]};
    if (frame[1]) w1 <= {w1[29:0], rise[1], fall[1]};
  end
endmodule

// file: sim/tdc_event_readout_tb_top.sv
// Scenario bench of the event readout with a serial receiver model.
// Assumes default depths; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
module tdc_event_readout_tb_top;
  logic clk, rst, sy, ch, cl, cwe, ewe, ri, m32, du, scv, scr, lk, lo;
  logic [511:0] hp;
  logic [3:0] cen, ca;
  logic [9:0] dh, dl, odh, odl;
  logic [23:0] ei, ep, e0;
  logic [1:0] ps, sr, sf, sfr, got;
  logic [31:0] scd, w0, w1;
  logic [31:0] q[$];
  logic [11:0] ts, a;
  logic [127:0] dt;
  int failures, n_tests, k;
  tdcr_readout u_dut (.clk(clk), .rst(rst), .hit_pattern(hp), .sync_in(sy), .cmp_hi(ch),
    .cmp_lo(cl), .cfg_we(cwe), .cfg_chan_en(cen), .cfg_dac_hi(dh), .cfg_dac_lo(dl),
    .epoch_init_we(ewe), .epoch_init(ei), .ro_init(ri), .cfg_mode32(m32), .cfg_pw_sel(ps),
    .cfg_dual(du), .sc_valid(scv), .sc_data(scd), .sc_ready(scr), .dac_hi(odh),
    .dac_lo(odl), .lock_err(lk), .ts_count(ts), .epoch_count(ep), .chan_active(ca),
    .dead_time(dt), .ser_rise(sr), .ser_fall(sf), .ser_frame(sfr));
  tdcr_backend_model u_be (.clk(clk), .rise(sr), .fall(sf), .frame(sfr), .got(got),
    .w0(w0), .w1(w1));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (got[0] === 1'h1) q.push_back(w0);
    if (got[1] === 1'h1) q.push_back(w1);
  end
  function automatic logic [127:0] pat(int b0, int b1);
    return (128'h1 << b1) - (128'h1 << b0);
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic lim(int i, int n);
    if (i >= n) begin
      failures++;
      $display("mismatch %0t timeout", $time);
      results;
    end
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Finds a received word in any order, waiting for it if needed
  task automatic seek(logic [31:0] m, logic [31:0] e);
    n_tests++;
    for (k = 0; k < 3000; k++) begin
      foreach (q[i]) if ((q[i] & m) === e) begin
        q.delete(i);
        return;
      end
      tick(1);
    end
    lim(k, 3000);
  endtask
  task automatic idle;
    int n;
    n = 0;
    for (k = 0; k < 3000 && n < 20; k++) begin
      n = (sfr === 2'h0) ? n + 1 : 0;
      tick(1);
    end
    lim(k, 3000);
  endtask
  // Rising edge at tap 10, falling edge at tap 70 gap cycles later
  task automatic hit(int c, int gap);
    hp[c*128+:128] = pat(10, 128);
    tick(1);
    hp[c*128+:128] = ~128'h0;
    tick(gap - 1);
    hp[c*128+:128] = pat(0, 70);
    tick(1);
    hp = '0;
  endtask
  task automatic t_reset;
    chk(32'(ca), 32'hf);
    chk(32'(odh), 32'h0);
    chk(32'(scr), 32'h1);
  endtask
  task automatic t_cfg;
    cwe = 1'h1;
    cen = 4'h5;
    dh = 10'h2aa;
    dl = 10'h155;
    tick(1);
    cwe = 1'h0;
    chk(32'(ca), 32'h5);
    chk(32'(odh), 32'h2aa);
    chk(32'(odl), 32'h155);
  endtask
  task automatic t_lock;
    for (int i = 0; i < 4; i++) begin
      {ch, cl} = 2'(i == 0 ? 2 : i == 2 ? 1 : 0);
      tick(4);
      chk(32'(lk), 32'(i % 2 == 0));
    end
  endtask
  task automatic t_ts;
    a = ts;
    tick(10);
    chk(32'(ts), 32'(12'(a + 12'ha)));
    for (k = 0; k < 4100 && ts !== 12'hfff; k++) tick(1);
    lim(k, 4100);
    e0 = ep;
    tick(1);
    chk(32'(ts), 32'h0);
    chk(32'(ep), 32'(24'(e0 + 24'h1)));
  endtask
  task automatic t_sync;
    ei = 24'h00abcd;
    ewe = 1'h1;
    tick(1);
    ewe = 1'h0;
    sy = 1'h1;
    tick(3);
    chk(32'(ts), 32'h0);
    chk(32'(ep), 32'h00abcd);
    sy = 1'h0;
    seek(32'hffffff, 32'h800001);
    seek(32'hffffff, 32'h800002);
    seek(32'hc00fff, 32'h400bcd);
  endtask
  task automatic t_hit;
    hit(2, 2);
    seek(32'hf8007f, 32'h20000a);
    seek(32'hf8007f, 32'h280046);
    idle;
  endtask
  task automatic t_slow;
    m32 = 1'h1;
    scd = 32'h5a3c9617;
    scv = 1'h1;
    for (k = 0; k < 100 && scr !== 1'h1; k++) tick(1);
    lim(k, 100);
    tick(1);
    scv = 1'h0;
    seek(32'hffffffff, 32'h5a3c9617);
  endtask
  task automatic t_pw;
    int w;
    for (int s = 0; s < 4; s++) begin
      ps = 2'(s);
      w = 444 >> s;
      hit(0, 3);
      seek(32'hf0007fff, 32'h0a00 | 32'(w > 255 ? 255 : w));
      tick(10);
    end
  endtask
  task automatic t_flood;
    du = 1'h1;
    lo = 1'h0;
    for (int i = 0; i < 80; i++) begin
      hp[127:0] = pat(10, 70);
      sy = (i >= 30 && i < 33);
      if (scr === 1'h0) lo = 1'h1;
      tick(1);
    end
    hp = '0;
    sy = 1'h0;
    chk(32'(lo), 32'h1);
    for (k = 0; k < 3000 && scr !== 1'h1; k++) tick(1);
    lim(k, 3000);
    idle;
    chk(32'(dt[15:0] != 16'h0), 32'h1);
    chk(32'(dt[31:16] != 16'h0), 32'h1);
  endtask
  task automatic t_init;
    ri = 1'h1;
    tick(1);
    ri = 1'h0;
    chk(32'(ca), 32'h0);
    tick(20);
    chk(32'(ca), 32'h0);
    sy = 1'h1;
    tick(3);
    sy = 1'h0;
    for (k = 0; k < 3000 && ca !== 4'h5; k++) tick(1);
    lim(k, 3000);
    chk(32'(ca), 32'h5);
  endtask
  initial begin
    {rst, sy, ch, cl, cwe, ewe, ri, m32, du, scv} = 10'h200;
    hp = '0;
    cen = 4'h0;
    dh = 10'h0;
    dl = 10'h0;
    ei = 24'h0;
    ps = 2'h0;
    scd = 32'h0;
    failures = 0;
    n_tests = 0;
    tick(2);
    rst = 1'h0;
    tick(1);
    t_reset;
    t_cfg;
    t_lock;
    t_ts;
    t_sync;
    t_hit;
    t_slow;
    t_pw;
    t_flood;
    t_init;
    results;
  end
endmodule
